/* logic/cgt_pkg.sv */
`default_nettype none
package cgt_pkg;
  // bus geometry
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          STRB_W        = DATA_W / 8;
  // register indices, byte address is four times the index
  localparam logic [5:0]  IDX_GAIN      = 6'h03;
  localparam logic [5:0]  IDX_OFFS      = 6'h0A;
  localparam logic [5:0]  IDX_STATUS    = 6'h0E;
  localparam logic [5:0]  IDX_FS_UV     = 6'h0F;
  localparam logic [5:0]  IDX_OFFS_UV   = 6'h10;
  // register words and reset values
  localparam int          REG_W         = 16;
  localparam logic [15:0] GAIN_WORD_RST = 16'h807F;
  localparam logic [15:0] OFFS_WORD_RST = 16'h007F;
  // field positions
  localparam int          GAIN_MSB      = 15;
  localparam int          GAIN_LSB      = 7;
  localparam int          OFFS_MSB      = 15;
  localparam int          OFFS_LSB      = 8;
  localparam int          SIGN_BIT      = 7;
  localparam int          RSVD_MSB      = 6;
  localparam logic [6:0]  RSVD_ONES     = 7'h7F;
  localparam int          STAT_GAIN_OK  = 0;
  localparam int          STAT_RSVD_BAD = 1;
  // gain code points
  localparam logic [8:0]  GAIN_MID      = 9'h100;
  localparam logic [8:0]  GAIN_FULL     = 9'h1FF;
  localparam logic [8:0]  GAIN_REC_LO   = 9'h0C0;
  localparam logic [8:0]  GAIN_REC_HI   = 9'h1C0;
  // offset code points
  localparam logic [7:0]  OFFS_FULL     = 8'hFF;
  // analogue figures in microvolts
  localparam logic [31:0] FS_MIN_UV     = 32'h00088B80;
  localparam logic [31:0] FS_MAX_UV     = 32'h000CD140;
  localparam logic [31:0] OFFS_MAX_UV   = 32'h0000AFC8;
  localparam int          FS_UV_W       = 20;
  localparam int          OFFS_UV_W     = 17;
  localparam logic [19:0] FS_RST_UV     = 20'hAAE60;
  // responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_GAIN, SEL_OFFS, SEL_STATUS, SEL_FS_UV, SEL_OFFS_UV
  } cgt_sel_type;
endpackage
`default_nettype wire

/* logic/cgt_trim_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cgt_trim_if;
  import cgt_pkg::*;
  logic [8:0]           gain_code;
  logic [7:0]           offs_mag;
  logic                 offs_neg;
  logic [FS_UV_W-1:0]   fs_uv;
  logic [OFFS_UV_W-1:0] offs_uv;
  modport regs (output gain_code, output offs_mag, output offs_neg, input fs_uv, input offs_uv);
  modport map  (input gain_code, input offs_mag, input offs_neg, output fs_uv, output offs_uv);
endinterface
`default_nettype wire

/* logic/cgt_trim_map.sv */
`timescale 1ns/1ps
`default_nettype none
module cgt_trim_map
  import cgt_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  cgt_trim_if.map   trim
);
  logic [31:0] fs_span;
  logic [31:0] fs_calc;
  logic [31:0] offs_calc;

  // linear, monotonic code to voltage maps, end points exact
  always_comb begin
    fs_span   = FS_MAX_UV - FS_MIN_UV;
    fs_calc   = FS_MIN_UV + (32'(trim.gain_code) * fs_span) / 32'(GAIN_FULL);
    offs_calc = (32'(trim.offs_mag) * OFFS_MAX_UV) / 32'(OFFS_FULL);
  end

  // registered results, new code takes effect one clock later with no calibration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim.fs_uv   <= FS_RST_UV;
      trim.offs_uv <= '0;
    end else begin
      trim.fs_uv <= fs_calc[FS_UV_W-1:0];
      if (trim.offs_neg) begin
        trim.offs_uv <= -offs_calc[OFFS_UV_W-1:0];
      end else begin
        trim.offs_uv <= offs_calc[OFFS_UV_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

/* logic/cgt_trim_regs.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - bits 15:7 of the gain register form a 9-bit code that scales full-scale range linearly.
// - the gain code spans plus or minus twenty percent around the nominal range.
// - code zero gives 560 mV, the midpoint 700 mV and all ones 840 mV peak-to-peak.
// - a new gain code applies directly and never starts or needs a calibration.
// - after reset the gain code holds the midpoint, meaning no adjustment.
// - bits 15:8 of the offset register are a magnitude that shifts offset linearly.
// - magnitude zero gives zero offset and full magnitude gives 45 mV.
// - each magnitude step moves the offset by about 0.176 mV.
// - bit 7 of the offset register picks polarity, zero positive and one negative.
// - after reset the offset magnitude is zero and the polarity positive.
module cgt_trim_regs
  import cgt_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [DATA_W-1:0]    s_axi_wdata,
  input  wire logic [STRB_W-1:0]    s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [8:0]                gain_code,
  output logic [7:0]                offs_mag,
  output logic                      offs_neg,
  output logic [FS_UV_W-1:0]        fs_range_uv,
  output logic [OFFS_UV_W-1:0]      offs_uv
);
  cgt_trim_if trim ();

  logic [REG_W-1:0]  gain_word_q;
  logic [REG_W-1:0]  offs_word_q;
  logic              rsvd_bad_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic              aw_full_q;
  logic              w_full_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0]        rresp_q;
  logic              do_write;
  cgt_sel_type       wsel;
  cgt_sel_type       rsel;
  logic [REG_W-1:0]  merged;
  logic              gain_ok;

  // byte addresses of the mapped words
  localparam logic [ADDR_W-1:0] ADDR_GAIN    = {IDX_GAIN, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_OFFS    = {IDX_OFFS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_STATUS  = {IDX_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_FS_UV   = {IDX_FS_UV, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_OFFS_UV = {IDX_OFFS_UV, 2'h0};

  // map a byte address to a register, word aligned only
  function automatic cgt_sel_type addr_sel(input logic [ADDR_W-1:0] addr);
    cgt_sel_type sel;
    sel = SEL_NONE;
    if (addr == ADDR_GAIN) begin
      sel = SEL_GAIN;
    end else if (addr == ADDR_OFFS) begin
      sel = SEL_OFFS;
    end else if (addr == ADDR_STATUS) begin
      sel = SEL_STATUS;
    end else if (addr == ADDR_FS_UV) begin
      sel = SEL_FS_UV;
    end else if (addr == ADDR_OFFS_UV) begin
      sel = SEL_OFFS_UV;
    end
    return sel;
  endfunction

  // true for the two writable trim words
  function automatic logic is_trim(input cgt_sel_type sel);
    return (sel == SEL_GAIN) || (sel == SEL_OFFS);
  endfunction

  // gain code field of a gain trim word
  function automatic logic [8:0] gain_field(input logic [REG_W-1:0] word);
    return word[GAIN_MSB:GAIN_LSB];
  endfunction

  // offset magnitude field of an offset trim word
  function automatic logic [7:0] offs_field(input logic [REG_W-1:0] word);
    return word[OFFS_MSB:OFFS_LSB];
  endfunction

  // byte-lane merge of the low half word, reserved bits kept at ones
  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                               input logic [DATA_W-1:0] wd,
                                               input logic [STRB_W-1:0] st);
    logic [REG_W-1:0] res;
    res = old;
    for (int b = 0; b < REG_W / 8; b++) begin
      if (st[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    res[RSVD_MSB:0] = RSVD_ONES;
    return res;
  endfunction

  // write fires once address and data are both held and no response is pending
  always_comb begin
    do_write = aw_full_q && w_full_q && !bvalid_q;
    wsel     = addr_sel(awaddr_q);
    rsel     = addr_sel(s_axi_araddr);
  end

  // status flag: gain code inside the recommended window
  always_comb begin
    gain_ok = (gain_field(gain_word_q) >= GAIN_REC_LO) &&
              (gain_field(gain_word_q) <= GAIN_REC_HI);
  end

  // lane merge into the addressed trim word, reserved bits forced to ones
  always_comb begin
    merged = '0;
    if (wsel == SEL_GAIN) begin
      merged = merge16(gain_word_q, wdata_q, wstrb_q);
    end else if (wsel == SEL_OFFS) begin
      merged = merge16(offs_word_q, wdata_q, wstrb_q);
    end
  end

  // write address channel, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (s_axi_awvalid && awready_q) begin
      aw_full_q <= 1'b1;
      awready_q <= 1'b0;
      awaddr_q  <= s_axi_awaddr;
    end else if (bvalid_q && s_axi_bready) begin
      aw_full_q <= 1'b0;
      awready_q <= 1'b1;
    end else if (!aw_full_q) begin
      awready_q <= 1'b1;
    end
  end

  // write data channel, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end else if (s_axi_wvalid && wready_q) begin
      w_full_q <= 1'b1;
      wready_q <= 1'b0;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (bvalid_q && s_axi_bready) begin
      w_full_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (!w_full_q) begin
      wready_q <= 1'b1;
    end
  end

  // write response valid, stands until bready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // write response code, error for anything but the two trim registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= RESP_OKAY;
    end else if (do_write) begin
      bresp_q <= is_trim(wsel) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // gain trim word, midpoint after reset, applied with no calibration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gain_word_q <= GAIN_WORD_RST;
    end else if (do_write && wsel == SEL_GAIN) begin
      gain_word_q <= merged;
    end
  end

  // offset trim word, zero positive offset after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offs_word_q <= OFFS_WORD_RST;
    end else if (do_write && wsel == SEL_OFFS) begin
      offs_word_q <= merged;
    end
  end

  // flags whether the last trim write with lane 0 strobed had reserved bits 6:0 not all ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsvd_bad_q <= 1'b0;
    end else if (do_write && is_trim(wsel) && wstrb_q[0]) begin
      rsvd_bad_q <= (wdata_q[RSVD_MSB:0] != RSVD_ONES);
    end
  end

  // read address ready, one read in flight, back after the data handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else if (s_axi_arvalid && arready_q) begin
      arready_q <= 1'b0;
    end else if (!rvalid_q || s_axi_rready) begin
      arready_q <= 1'b1;
    end
  end

  // read valid stands until rready
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
    end else if (s_axi_arvalid && arready_q) begin
      rvalid_q <= 1'b1;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // read data and response, trim words themselves read as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      unique case (rsel)
        SEL_GAIN, SEL_OFFS: rdata_q <= '0;
        SEL_STATUS: begin
          rdata_q[STAT_GAIN_OK]  <= gain_ok;
          rdata_q[STAT_RSVD_BAD] <= rsvd_bad_q;
        end
        SEL_FS_UV:   rdata_q <= DATA_W'(trim.fs_uv);
        SEL_OFFS_UV: rdata_q <= DATA_W'(signed'(trim.offs_uv));
        SEL_NONE:    rresp_q <= RESP_SLVERR;
      endcase
    end
  end

  // trim fields toward the analogue map
  assign trim.gain_code = gain_field(gain_word_q);
  assign trim.offs_mag  = offs_field(offs_word_q);
  assign trim.offs_neg  = offs_word_q[SIGN_BIT];

  cgt_trim_map u_map (
    .aclk    (aclk),
    .aresetn (aresetn),
    .trim    (trim.map)
  );

  // bus outputs, all from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // trim outputs, fields of the stored words and the registered map results
  assign gain_code     = gain_field(gain_word_q);
  assign offs_mag      = offs_field(offs_word_q);
  assign offs_neg      = offs_word_q[SIGN_BIT];
  assign fs_range_uv   = trim.fs_uv;
  assign offs_uv       = trim.offs_uv;
endmodule
`default_nettype wire

/* testbench/cgt_trim_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cgt_trim_props
  import cgt_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic [ADDR_W-1:0]    s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [DATA_W-1:0]    s_axi_rdata,
  input wire logic [1:0]           s_axi_rresp,
  input wire logic                 s_axi_rvalid,
  input wire logic [8:0]           gain_code,
  input wire logic [7:0]           offs_mag,
  input wire logic                 offs_neg,
  input wire logic [FS_UV_W-1:0]   fs_range_uv,
  input wire logic [OFFS_UV_W-1:0] offs_uv
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // trims sit at their power-on values when reset lifts
  AST_RST_VAL: assert property (
    $rose(aresetn) |-> gain_code == GAIN_MID && offs_mag == 8'h00 && !offs_neg)
    else $error("trim outputs not at reset values");
  // range follows the gain code one edge later
  AST_FS_MAP: assert property (
    $past(aresetn) |-> fs_range_uv ==
      20'(32'd560000 + 32'($past(gain_code)) * 32'd280000 / 32'd511))
    else $error("full-scale range mismatch");
  // offset follows magnitude and sign one edge later
  AST_OFFS_MAP: assert property (
    offs_uv == 17'($past(offs_neg) ? 32'd0 - 32'($past(offs_mag)) * 32'd45000 / 32'd255
      : 32'($past(offs_mag)) * 32'd45000 / 32'd255))
    else $error("offset mismatch");
  AST_WR_DONE: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after it was taken");
  AST_RD_WO: assert property (
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == 8'h0C || s_axi_araddr == 8'h28)
      |=> s_axi_rvalid && s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY)
    else $error("trim register read not zero");
  AST_GAIN_CHG: assert property (
    $changed(gain_code) |-> $rose(s_axi_bvalid))
    else $error("gain changed without a write");
  AST_OFFS_CHG: assert property (
    $changed({offs_mag, offs_neg}) |-> $rose(s_axi_bvalid))
    else $error("offset changed without a write");
  AST_WR_BUSY: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
endmodule
bind cgt_trim_regs cgt_trim_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .gain_code, .offs_mag, .offs_neg, .fs_range_uv,
  .offs_uv);
`default_nettype wire

/* testbench/channel_gain_offset_trim_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("FAIL %0t got %h exp %h", $time, g, e); end end
module channel_gain_offset_trim_regs_tb;
  import cgt_pkg::*;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] d;
    logic [8:0]  g;
    logic [7:0]  m;
    logic        n;
  } cgt_row_type;
  logic                 aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
  logic [2:0]           s_axi_awprot, s_axi_arprot;
  logic                 s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata;
  logic [STRB_W-1:0]    s_axi_wstrb;
  logic [1:0]           s_axi_bresp, s_axi_rresp;
  logic                 s_axi_arready, s_axi_rvalid, s_axi_rready, offs_neg;
  logic [8:0]           gain_code;
  logic [7:0]           offs_mag;
  logic [FS_UV_W-1:0]   fs_range_uv;
  logic [OFFS_UV_W-1:0] offs_uv;
  int                   n_fail, tests_run;
  // rows keep reserved bits at ones; 0C0 and 1C0 are the recommended bounds
  cgt_row_type rows [8] = '{'{8'h0C, 16'h007F, 9'h000, 8'h00, 1'b0},
    '{8'h0C, 16'hFFFF, 9'h1FF, 8'h00, 1'b0}, '{8'h0C, 16'h607F, 9'h0C0, 8'h00, 1'b0},
    '{8'h0C, 16'hE07F, 9'h1C0, 8'h00, 1'b0}, '{8'h28, 16'hFF7F, 9'h1C0, 8'hFF, 1'b0},
    '{8'h28, 16'hFFFF, 9'h1C0, 8'hFF, 1'b1}, '{8'h28, 16'h01FF, 9'h1C0, 8'h01, 1'b1},
    '{8'h0C, 16'h807F, 9'h100, 8'h01, 1'b1}};

  cgt_trim_regs u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gain_code,
    .offs_mag, .offs_neg, .fs_range_uv, .offs_uv);

  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r,
                    input logic [STRB_W-1:0] s = 4'hF);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(negedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // compare trims and derived figures with the expected codes
  task automatic chk_out(input logic [8:0] g, input logic [7:0] m, input logic n);
    int v;
    v = int'(m) * 45000 / 255;
    `CHK(gain_code, g)
    `CHK(fs_range_uv, 20'(560000 + int'(g) * 280000 / 511))
    `CHK({offs_mag, offs_neg}, {m, n})
    `CHK(offs_uv, 17'(n ? -v : v))
  endtask

  task automatic summarize();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    `CHK({s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid}, 5'h00)
    `CHK(fs_range_uv, 20'hAAE60)
    @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // watchdog
  initial begin
    #4000;
    n_fail++;
    summarize();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h000000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    n_fail = 0;
    tests_run = 0;
    do_reset();
    chk_out(GAIN_MID, 8'h00, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      `CHK(r, RESP_OKAY)
      chk_out(rows[i].g, rows[i].m, rows[i].n);
    end
    // trim registers have no read-back
    rd(8'h0C, d, r);
    `CHK({d, r}, {32'h0, RESP_OKAY})
    rd(8'h28, d, r);
    `CHK({d, r}, {32'h0, RESP_OKAY})
    // unmapped places are refused and leave trims alone
    wr(8'h04, 16'hFFFF, r);
    `CHK(r, RESP_SLVERR)
    chk_out(9'h100, 8'h01, 1'b1);
    rd(8'h08, d, r);
    `CHK(r, RESP_SLVERR)
    // reserved bits written as zeros: stored as ones, flagged in status
    wr(8'h0C, 16'h8000, r);
    `CHK(r, RESP_OKAY)
    rd(8'h38, d, r);
    `CHK({d, r}, {32'h00000003, RESP_OKAY})
    rd(8'h3C, d, r);
    `CHK({d, r}, {32'h000AAF71, RESP_OKAY})
    rd(8'h40, d, r);
    `CHK({d, r}, {32'hFFFFFF50, RESP_OKAY})
    // upper lane only: magnitude changes, sign and reserved bits stay
    wr(8'h28, 16'hAA00, r, 4'h2);
    `CHK(r, RESP_OKAY)
    chk_out(9'h100, 8'hAA, 1'b1);
    // reset in mid-run brings back the defaults
    @(posedge aclk);
    do_reset();
    chk_out(GAIN_MID, 8'h00, 1'b0);
    summarize();
  end
endmodule
`undef CHK
`default_nettype wire
